// ==== core/pin_mux_consts.svh ====
// Constants for the boot-mode strap capture and pin-function multiplexer.
// Assumes inclusion by bare name from the package and the design module.
`ifndef PIN_MUX_CONSTS_SVH
`define PIN_MUX_CONSTS_SVH

// Avalon byte addresses of the word registers.
`define ADDR_W          4
`define OFS_CTRL        4'h0
`define OFS_PINS        4'h4
`define OFS_IRQ_STATUS  4'h8
`define OFS_IRQ_MASK    4'hC

// Control register fields.
`define CTRL_SDIR_LO    0
`define CTRL_SDIR_HI    3
`define CTRL_IDIR_LO    4
`define CTRL_IDIR_HI    7
`define CTRL_SOUT_LO    8
`define CTRL_SOUT_HI    11
`define CTRL_IOUT_LO    12
`define CTRL_IOUT_HI    15
`define CTRL_SER_ALT    16
`define CTRL_CFG_EDGE   17
`define CTRL_SIRQ0_EDGE 18
`define CTRL_SIRQ1_EDGE 19
`define CTRL_SER_FOUT   20
`define CTRL_W          21
`define CTRL_RESET      21'h000000

// Pin status register fields.
`define PINS_STRAP_LO   0
`define PINS_STRAP_HI   3
`define PINS_IRQF_LO    4
`define PINS_IRQF_HI    7
`define PINS_SER_FIN    8
`define PINS_CAP_LO     9
`define PINS_CAP_HI     12
`define PINS_HOST       13
`define PINS_W          14

// Interrupt event bit positions, shared by status and mask.
`define EV_CFG          0
`define EV_LVL1         1
`define EV_LVL0         2
`define EV_EDGE         3
`define EV_SIRQ1        4
`define EV_SIRQ0        5
`define EV_W            6
`define EV_RESET        6'h00

// Pin positions inside the interrupt/flag group and the strap group.
`define IRQF_EDGE       0
`define IRQF_LVL0       1
`define IRQF_LVL1       2
`define IRQF_CFG        3
`define STRAP_MEM_MODE  2

`define DATA_W          24
`define ADDR_OUT_W      14
`define BYTE_HI_W       8
`define HOST_LOW_W      8

`endif

// ==== core/pin_mux_pkg.sv ====
// Types shared by the pin-function multiplexer and its surroundings.
// Assumes the constants header is on the include path.
`include "pin_mux_consts.svh"

package pin_mux_pkg;

  // Memory-interface mode, one-hot.
  typedef enum logic [1:0] {
    MODE_FULL = 2'b01,
    MODE_HOST = 2'b10
  } mem_mode_e;

  // External memory request from the processor core.
  typedef struct packed {
    logic [`ADDR_OUT_W-1:0] addr;
    logic [`DATA_W-1:0]     data;
    logic                   drive;
    logic                   byteAccess;
    logic [`BYTE_HI_W-1:0]  byteAddrHigh;
  } mem_req_s;

  // Serial port pins that have an alternate function.
  typedef struct packed {
    logic rxData;
    logic rxFrame;
    logic txFrame;
  } serial_pins_s;

endpackage

// ==== core/boot_mode_pin_function_mux.sv ====
// Strap capture, flag pins, interrupt pins and memory-interface muxing.
// Assumes pins are synchronous to clk and the bench resolves two-way wires
// from the active-low output enables.
// Behaviour
// - Sample mode straps only during reset.
// - After reset straps become programmable flags.
// - Memory-mode strap picks full or host.
// - Full mode drives 14 address, 24 data.
// - Shared pins are interrupt and flag together.
// - Unmasked asserted shared pin raises its interrupt.
// - Edge or level interrupt sensitivity: fixed per pin, selectable on the configurable and serial lines.
// - Serial port pins switch to interrupts, flags.
// - Bus mode fixed; serial mux runtime.
//
// The register addresses and the Avalon-MM interface to the registers were left to the implementer.
`timescale 1ns/1ns
`include "pin_mux_consts.svh"

module boot_mode_pin_function_mux (
  input  wire logic                         clk,
  input  wire logic                         reset,
  input  wire logic [`ADDR_W-1:0]           address,
  input  wire logic                         read,
  input  wire logic                         write,
  input  wire logic [31:0]                  writedata,
  output logic      [31:0]                  readdata,
  output logic                              waitrequest,
  output logic                              irq,
  input  wire logic [3:0]                   strapSharedFlagsIn,
  output logic      [3:0]                   strapSharedFlagsOut,
  output logic      [3:0]                   strapSharedFlagsOen,
  input  wire logic [3:0]                   irqSharedFlagsIn,
  output logic      [3:0]                   irqSharedFlagsOut,
  output logic      [3:0]                   irqSharedFlagsOen,
  output logic      [`EV_W-1:0]             vectorRequest,
  input  wire pin_mux_pkg::serial_pins_s    serialPinsIn,
  output logic                              serialTxPin,
  input  wire logic                         coreTxData,
  output pin_mux_pkg::serial_pins_s         coreSerialIn,
  output logic                              hostMode,
  input  wire pin_mux_pkg::mem_req_s        memRequest,
  output logic      [`ADDR_OUT_W-1:0]       externalAddressOut,
  output logic      [`DATA_W-1:0]           externalDataOut,
  output logic      [`DATA_W-1:0]           externalDataOen,
  input  wire logic [`DATA_W-1:0]           externalDataIn,
  output logic      [`DATA_W-1:0]           coreDataIn
);
  import pin_mux_pkg::*;

  logic [`CTRL_W-1:0]     ctrlReg;
  logic [`CTRL_W-1:0]     ctrlNext;
  logic [`EV_W-1:0]       statusReg;
  logic [`EV_W-1:0]       statusNext;
  logic [`EV_W-1:0]       maskReg;
  logic [`EV_W-1:0]       maskNext;
  logic [3:0]             strapCaptureReg;
  mem_mode_e              memModeReg;
  logic                   hostModeReg;
  logic                   waitReg;
  logic [31:0]            readdataReg;
  logic [31:0]            readdataNext;
  logic [3:0]             irqPinPrevReg;
  serial_pins_s           serialPrevReg;
  logic                   irqReg;
  logic [`EV_W-1:0]       vectorReg;
  logic [3:0]             strapOutReg;
  logic [3:0]             strapOenReg;
  logic [3:0]             irqFlagOutReg;
  logic [3:0]             irqFlagOenReg;
  logic                   serialTxReg;
  serial_pins_s           coreSerialReg;
  logic [`ADDR_OUT_W-1:0] addrOutReg;
  logic [`DATA_W-1:0]     dataOutReg;
  logic [`DATA_W-1:0]     dataOenReg;
  logic [`DATA_W-1:0]     coreDataReg;

  // Bus decode. A request is answered at its second edge.
  wire                    busReq     = read | write;
  wire                    accept     = busReq & ~waitReg;
  wire                    wrAccept   = accept & write;
  wire                    hitCtrl    = address == `OFS_CTRL;
  wire                    hitPins    = address == `OFS_PINS;
  wire                    hitStatus  = address == `OFS_IRQ_STATUS;
  wire                    hitMask    = address == `OFS_IRQ_MASK;
  wire                    waitNext   = ~(busReq & waitReg);
  wire                    readLoad   = busReq & waitReg & read;

  wire                    serialAlt  = ctrlReg[`CTRL_SER_ALT];
  wire                    isFull     = memModeReg == MODE_FULL;

  wire [3:0]              strapDir   = ctrlReg[`CTRL_SDIR_HI:`CTRL_SDIR_LO];
  wire [3:0]              irqDir     = ctrlReg[`CTRL_IDIR_HI:`CTRL_IDIR_LO];
  wire [3:0]              strapVal   = ctrlReg[`CTRL_SOUT_HI:`CTRL_SOUT_LO];
  wire [3:0]              irqVal     = ctrlReg[`CTRL_IOUT_HI:`CTRL_IOUT_LO];

  // interrupt detection reads the pin whether a flag drives it or not.
  wire [3:0]              irqLow     = ~irqSharedFlagsIn;
  wire [3:0]              irqFall    = irqPinPrevReg & ~irqSharedFlagsIn;
  wire                    rfsFall    = serialPrevReg.rxFrame &
                                       ~serialPinsIn.rxFrame;
  wire                    tfsFall    = serialPrevReg.txFrame &
                                       ~serialPinsIn.txFrame;

  // configurable line picks edge or level; the fixed ones do not.
  wire                    evCfg      = ctrlReg[`CTRL_CFG_EDGE] ?
                                       irqFall[`IRQF_CFG] :
                                       irqLow[`IRQF_CFG];
  wire                    evSirq0    = ctrlReg[`CTRL_SIRQ0_EDGE] ?
                                       rfsFall : ~serialPinsIn.rxFrame;
  wire                    evSirq1    = ctrlReg[`CTRL_SIRQ1_EDGE] ?
                                       tfsFall : ~serialPinsIn.txFrame;

  // the serial interrupts exist only in the alternate configuration.
  wire [`EV_W-1:0]        events     = {serialAlt & evSirq0,
                                        serialAlt & evSirq1,
                                        irqFall[`IRQF_EDGE],
                                        irqLow[`IRQF_LVL0],
                                        irqLow[`IRQF_LVL1],
                                        evCfg};

  wire [`EV_W-1:0]        clearBits  = (wrAccept & hitStatus) ?
                                       writedata[`EV_W-1:0] : `EV_RESET;
  wire [`EV_W-1:0]        pendingNow = statusReg & maskReg;

  wire [`PINS_W-1:0]      pinsView   = {~isFull,
                                        strapCaptureReg,
                                        serialPinsIn.rxData,
                                        irqSharedFlagsIn,
                                        strapSharedFlagsIn};

  // on byte accesses the top data byte carries the byte-memory address.
  wire [`DATA_W-1:0]      fullData   = memRequest.byteAccess ?
                                       {memRequest.byteAddrHigh,
                                        memRequest.data[`DATA_W-
                                        `BYTE_HI_W-1:0]} :
                                       memRequest.data;
  // host mode leaves only the lowest address line for decoding.
  wire [`ADDR_OUT_W-1:0]  hostAddr   = {{(`ADDR_OUT_W-1){1'b0}},
                                        memRequest.addr[0]};
  wire [`DATA_W-1:0]      hostData   = {fullData[`DATA_W-1:`HOST_LOW_W],
                                        {`HOST_LOW_W{1'b0}}};
  wire [`DATA_W-1:0]      fullOen    = {`DATA_W{~memRequest.drive}};
  wire [`DATA_W-1:0]      hostOen    = {{(`DATA_W-`HOST_LOW_W){
                                        ~memRequest.drive}},
                                        {`HOST_LOW_W{1'b1}}};
  wire [`DATA_W-1:0]      hostIn     = {externalDataIn[`DATA_W-1:
                                        `HOST_LOW_W],
                                        {`HOST_LOW_W{1'b0}}};

  // Register writes. Set wins over a simultaneous write-one clear.
  always_comb begin
    ctrlNext   = ctrlReg;
    maskNext   = maskReg;
    statusNext = (statusReg & ~clearBits) | events;
    if (wrAccept && hitCtrl) begin
      ctrlNext = writedata[`CTRL_W-1:0];
    end
    if (wrAccept && hitMask) begin
      maskNext = writedata[`EV_W-1:0];
    end
  end

  // Read mux. Unmapped addresses read as zero and accept writes silently.
  always_comb begin
    readdataNext = 32'h00000000;
    if (hitCtrl) begin
      readdataNext[`CTRL_W-1:0] = ctrlReg;
    end else if (hitPins) begin
      readdataNext[`PINS_W-1:0] = pinsView;
    end else if (hitStatus) begin
      readdataNext[`EV_W-1:0] = statusReg;
    end else if (hitMask) begin
      readdataNext[`EV_W-1:0] = maskReg;
    end
  end

  // The wait cycle lets read data settle before the master takes it.
  always_ff @(posedge clk) begin
    if (reset) begin
      waitReg <= 1'b1;
    end else begin
      waitReg <= waitNext;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      readdataReg <= 32'h00000000;
    end else if (readLoad) begin
      readdataReg <= readdataNext;
    end else begin
      readdataReg <= readdataReg;
    end
  end

  // serial mux and flags follow software at any time.
  always_ff @(posedge clk) begin
    if (reset) begin
      ctrlReg <= `CTRL_RESET;
    end else begin
      ctrlReg <= ctrlNext;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      maskReg <= `EV_RESET;
    end else begin
      maskReg <= maskNext;
    end
  end

  // Status is sticky, so a level pin held low sets its bit again.
  always_ff @(posedge clk) begin
    if (reset) begin
      statusReg <= `EV_RESET;
    end else begin
      statusReg <= statusNext;
    end
  end

  // straps are looked at only while reset is high.
  // the last reset cycle's sample is what stays after release.
  always_ff @(posedge clk) begin
    if (reset) begin
      strapCaptureReg <= strapSharedFlagsIn;
    end else begin
      strapCaptureReg <= strapCaptureReg;
    end
  end

  // mode follows the memory-mode strap and freezes after reset.
  // bus pin function cannot change while running.
  always_ff @(posedge clk) begin
    if (reset) begin
      memModeReg  <= strapSharedFlagsIn[`STRAP_MEM_MODE] ? MODE_HOST :
                     MODE_FULL;
      hostModeReg <= strapSharedFlagsIn[`STRAP_MEM_MODE];
    end else begin
      memModeReg  <= memModeReg;
      hostModeReg <= hostModeReg;
    end
  end

  // Previous pin levels for falling-edge detection. They reset to the idle
  // high level, so no false edge follows reset.
  always_ff @(posedge clk) begin
    if (reset) begin
      irqPinPrevReg <= 4'hF;
    end else begin
      irqPinPrevReg <= irqSharedFlagsIn;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      serialPrevReg <= '1;
    end else begin
      serialPrevReg <= serialPinsIn;
    end
  end

  // unmasked pending events request their vector.
  always_ff @(posedge clk) begin
    if (reset) begin
      vectorReg <= `EV_RESET;
    end else begin
      vectorReg <= pendingNow;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      irqReg <= 1'b0;
    end else begin
      irqReg <= |pendingNow;
    end
  end

  // flag drivers stay off in reset, so straps are never fought.
  always_ff @(posedge clk) begin
    if (reset) begin
      strapOutReg <= 4'h0;
      strapOenReg <= 4'hF;
    end else begin
      strapOutReg <= strapVal;
      strapOenReg <= ~strapDir;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      irqFlagOutReg <= 4'h0;
      irqFlagOenReg <= 4'hF;
    end else begin
      irqFlagOutReg <= irqVal;
      irqFlagOenReg <= ~irqDir;
    end
  end

  // in the alternate set the data pins become flag in and flag out.
  always_ff @(posedge clk) begin
    if (reset) begin
      serialTxReg <= 1'b0;
    end else begin
      serialTxReg <= serialAlt ? ctrlReg[`CTRL_SER_FOUT] : coreTxData;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      coreSerialReg <= '0;
    end else begin
      coreSerialReg <= serialAlt ? '0 : serialPinsIn;
    end
  end

  // full mode drives all address lines and the whole data bus.
  // host mode keeps only the low address and upper data lines.
  always_ff @(posedge clk) begin
    if (reset) begin
      addrOutReg <= {`ADDR_OUT_W{1'b0}};
      dataOutReg <= {`DATA_W{1'b0}};
    end else begin
      addrOutReg <= isFull ? memRequest.addr : hostAddr;
      dataOutReg <= isFull ? fullData : hostData;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      dataOenReg  <= {`DATA_W{1'b1}};
      coreDataReg <= {`DATA_W{1'b0}};
    end else begin
      dataOenReg  <= isFull ? fullOen : hostOen;
      coreDataReg <= isFull ? externalDataIn : hostIn;
    end
  end

  assign readdata            = readdataReg;
  assign waitrequest         = waitReg;
  assign irq                 = irqReg;
  assign vectorRequest       = vectorReg;
  assign strapSharedFlagsOut = strapOutReg;
  assign strapSharedFlagsOen = strapOenReg;
  assign irqSharedFlagsOut   = irqFlagOutReg;
  assign irqSharedFlagsOen   = irqFlagOenReg;
  assign serialTxPin         = serialTxReg;
  assign coreSerialIn        = coreSerialReg;
  assign hostMode            = hostModeReg;
  assign externalAddressOut  = addrOutReg;
  assign externalDataOut     = dataOutReg;
  assign externalDataOen     = dataOenReg;
  assign coreDataIn          = coreDataReg;

endmodule // boot_mode_pin_function_mux

// ==== verif/pin_mux_sva.sv ====
// Port checker for the strap capture and pin-function multiplexer.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ns
module pin_mux_sva (
  input wire logic                  clk,
  input wire logic                  reset,
  input wire logic                  read,
  input wire logic                  write,
  input wire logic                  waitrequest,
  input wire logic                  irq,
  input wire logic [5:0]            vectorRequest,
  input wire logic                  hostMode,
  input wire pin_mux_pkg::mem_req_s memRequest,
  input wire logic [13:0]           externalAddressOut,
  input wire logic [23:0]           externalDataOut,
  input wire logic [23:0]           externalDataOen,
  input wire logic [23:0]           coreDataIn
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  a_wait_answer: assert property ((read || write) && waitrequest |=>
    !waitrequest)
    else $error("no answer one cycle after request");
  a_wait_pulse: assert property (!waitrequest |=> waitrequest)
    else $error("waitrequest low for more than one cycle");
  a_irq_vector: assert property (irq == (|vectorRequest))
    else $error("irq does not follow vector requests");
  a_mode_fixed: assert property (!$past(reset) |-> $stable(hostMode))
    else $error("memory mode changed outside reset");
  a_host_addr: assert property (hostMode |->
    externalAddressOut[13:1] == 13'h0000)
    else $error("host mode drives upper address lines");
  a_host_lanes: assert property (hostMode |->
    externalDataOen[7:0] == 8'hFF && coreDataIn[7:0] == 8'h00)
    else $error("host mode uses low data lanes");
  a_full_addr: assert property (!$past(reset) && !hostMode |->
    externalAddressOut == $past(memRequest.addr))
    else $error("full mode address not forwarded");
  a_full_drive: assert property (!$past(reset) && !hostMode &&
    $past(memRequest.drive) |-> externalDataOen == 24'h000000)
    else $error("full mode data lanes not driven");
  a_byte_high: assert property (!$past(reset) && !hostMode &&
    $past(memRequest.drive) && $past(memRequest.byteAccess) |->
    externalDataOut[23:16] == $past(memRequest.byteAddrHigh))
    else $error("byte address missing on upper data lanes");
  c_irq: cover property (irq);
  c_host: cover property (hostMode);
  c_write: cover property (write && !waitrequest);
endmodule // pin_mux_sva

bind boot_mode_pin_function_mux pin_mux_sva chk_u (.clk(clk), .reset(reset),
  .read(read), .write(write), .waitrequest(waitrequest), .irq(irq),
  .vectorRequest(vectorRequest), .hostMode(hostMode), .memRequest(memRequest),
  .externalAddressOut(externalAddressOut), .externalDataOut(externalDataOut),
  .externalDataOen(externalDataOen), .coreDataIn(coreDataIn));

// ==== verif/board_model.sv ====
// Board devices on the strap and interrupt/flag pins.
// Assumes the bench tells each device what to drive; pins have pull-ups.
`timescale 1ns/1ns
module board_model (
  input  wire logic [3:0] strapOut,
  input  wire logic [3:0] strapOen,
  input  wire logic [3:0] strapDrv,
  input  wire logic       strapHold,
  input  wire logic [3:0] irqOut,
  input  wire logic [3:0] irqOen,
  input  wire logic [3:0] irqPull,
  output logic      [3:0] strapIn,
  output logic      [3:0] irqIn
);
  // straps held through release, then let go so the pull-up wins.
  assign strapIn = (strapOut | strapOen) & (strapHold ? strapDrv : 4'hF);
  // open-drain devices and the flag driver meet as a wired AND.
  assign irqIn = (irqOut | irqOen) & irqPull;
endmodule // board_model

// ==== verif/tb.sv ====
// Self-checking bench for the strap capture and pin multiplexer.
// Assumes the board model resolves the shared pins from the enables.
`timescale 1ns/1ns
module tb;
  import pin_mux_pkg::*;
  logic         clk = 0, reset = 1, read = 0, write = 0, coreTxData = 0;
  logic         waitrequest, irq, hostMode, serialTxPin, strapHold = 1;
  logic [3:0]   address = 4'h0, strapDrv = 4'hB, irqPull = 4'hF;
  logic [3:0]   strapIn, strapOut, strapOen, irqIn, irqOut, irqOen;
  logic [31:0]  writedata = 0, readdata, rd, seed = 47;
  logic [63:0]  r;
  logic [5:0]   vectorRequest;
  logic [13:0]  externalAddressOut;
  logic [23:0]  externalDataOut, externalDataOen, coreDataIn, exp24;
  logic [23:0]  externalDataIn = 24'h000000;
  serial_pins_s serialPinsIn = 3'h7, coreSerialIn;
  mem_req_s     memRequest = '0;
  int           fail_count = 0, compares = 0;
  always #2 clk = ~clk;
  boot_mode_pin_function_mux dut_u (.clk(clk), .reset(reset),
    .address(address), .read(read), .write(write), .writedata(writedata),
    .readdata(readdata), .waitrequest(waitrequest), .irq(irq),
    .strapSharedFlagsIn(strapIn), .strapSharedFlagsOut(strapOut),
    .strapSharedFlagsOen(strapOen), .irqSharedFlagsIn(irqIn),
    .irqSharedFlagsOut(irqOut), .irqSharedFlagsOen(irqOen),
    .vectorRequest(vectorRequest), .serialPinsIn(serialPinsIn),
    .serialTxPin(serialTxPin), .coreTxData(coreTxData),
    .coreSerialIn(coreSerialIn), .hostMode(hostMode), .memRequest(memRequest),
    .externalAddressOut(externalAddressOut), .externalDataOut(externalDataOut),
    .externalDataOen(externalDataOen), .externalDataIn(externalDataIn),
    .coreDataIn(coreDataIn));
  board_model bm_u (.strapOut(strapOut), .strapOen(strapOen),
    .strapDrv(strapDrv), .strapHold(strapHold), .irqOut(irqOut),
    .irqOen(irqOen), .irqPull(irqPull), .strapIn(strapIn), .irqIn(irqIn));
  function automatic logic [31:0] nextRand();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(string name, logic [31:0] seen, logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic bus(logic we, logic [3:0] a, logic [31:0] wd);
    int n = 0;
    @(posedge clk);
    read <= !we;
    write <= we;
    address <= a;
    writedata <= wd;
    do begin
      @(posedge clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 50);
    if (n >= 50) begin
      fail_count++;
      complete_run();
    end
    rd = readdata;
    read <= 0;
    write <= 0;
  endtask
  task automatic tick(int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task automatic doReset(logic [3:0] s);
    @(posedge clk);
    reset <= 1;
    strapHold <= 1;
    strapDrv <= s;
    repeat (2) @(posedge clk);
    reset <= 0;
    @(posedge clk);
    strapHold <= 0;
    tick(1);
  endtask
  task automatic complete_run();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    #40000;
    fail_count++;
    complete_run();
  end
  initial begin
    doReset(4'hB);
    chk("hostMode", hostMode, 0);
    bus(0, 4'h4, 0);
    chk("pins", rd, {18'h0, 1'b0, 4'hB, 1'b1, 4'hF, 4'hF});
    bus(0, 4'h2, 0);
    chk("unmapped", rd, 0);
    for (int i = 0; i < 8; i++) begin
      r = {nextRand(), nextRand()};
      @(posedge clk);
      memRequest <= r[47:0];
      externalDataIn <= r[63:40];
      tick(1);
      chk("addr", externalAddressOut, memRequest.addr);
      chk("coreData", coreDataIn, externalDataIn);
      chk("oen", externalDataOen, {24{!memRequest.drive}});
      exp24 = memRequest.byteAccess ?
        {memRequest.byteAddrHigh, memRequest.data[15:0]} : memRequest.data;
      if (memRequest.drive)
        chk("data", externalDataOut, exp24);
    end
    bus(1, 4'hC, 32'h3F);
    bus(1, 4'h0, 32'h00000A0F);
    tick(1);
    chk("strapOut", strapOut, 4'hA);
    chk("strapOen", strapOen, 4'h0);
    bus(1, 4'h4, 32'hFFFFFFFF);
    bus(0, 4'h4, 0);
    chk("pinsFlags", rd[12:0], {4'hB, 1'b1, 4'hF, 4'hA});
    bus(1, 4'h0, 32'h00000A1F);
    tick(3);
    chk("irqOen", irqOen, 4'hE);
    chk("vector", vectorRequest, 6'h08);
    bus(1, 4'h8, 32'h08);
    tick(2);
    chk("edgeClear", irq, 0);
    bus(1, 4'hC, 0);
    @(posedge clk) irqPull <= 4'hD;
    tick(3);
    chk("masked", irq, 0);
    bus(1, 4'h8, 32'h04);
    bus(0, 4'h8, 0);
    chk("levelSticky", rd, 32'h04);
    bus(1, 4'hC, 32'h3F);
    tick(2);
    chk("unmasked", vectorRequest, 6'h04);
    chk("irqHigh", irq, 1);
    @(posedge clk) irqPull <= 4'hF;
    for (int m = 0; m < 2; m++) begin
      bus(1, 4'h0, 32'h00000A0F | (m << 17));
      bus(1, 4'h8, 32'h3F);
      @(posedge clk) irqPull <= 4'h7;
      tick(3);
      bus(1, 4'h8, 32'h3F);
      bus(0, 4'h8, 0);
      chk("cfgStatus", rd, m ? 0 : 1);
      @(posedge clk) irqPull <= 4'hF;
    end
    bus(1, 4'h0, 32'h00110000);
    bus(1, 4'h8, 32'h3F);
    @(posedge clk) serialPinsIn <= 3'b101;
    coreTxData <= 1;
    tick(3);
    chk("serialFlagOut", serialTxPin, 1);
    chk("coreSerial", coreSerialIn, 0);
    bus(0, 4'h8, 0);
    chk("serialIrq", rd, 32'h20);
    bus(1, 4'h0, 0);
    @(posedge clk) serialPinsIn <= 3'h7;
    coreTxData <= 0;
    tick(2);
    chk("serialTx", serialTxPin, 0);
    chk("coreSerialBack", coreSerialIn, 3'h7);
    doReset(4'h4);
    chk("hostMode", hostMode, 1);
    @(posedge clk) memRequest <= 48'hFFFFFFFFFFFF;
    tick(1);
    chk("hostAddr", externalAddressOut, 14'h0001);
    chk("hostOen", externalDataOen, 24'h0000FF);
    chk("hostData", externalDataOut[23:8], 16'hFFFF);
    chk("hostIn", coreDataIn, {externalDataIn[23:8], 8'h00});
    bus(0, 4'h4, 0);
    chk("pinsHost", rd[13:9], 5'h14);
    complete_run();
  end
endmodule // tb
